// file: logic/math_cop_device.sv
// Coprocessor end: port decode, stack, exceptions, busy and request 13
`timescale 1ns/1ps
module math_cop_device
	import math_cop_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	cop_link_if.device link,
	output logic protMode,
	output logic [EXC_COUNT-1:0] excFlags,
	output logic [3:0] stackDepth
);
	////////////////////////////////////////////////////////////////////
	logic byteWr, clearHit, resetHit, opcHit, opndHit;
	logic errNow, errRise, runEnd, stackOk;
	exec_state_t exState_r;
	logic [CNT_W-1:0] runCnt_r;
	logic [15:0] opcode_r;
	cop_op_t opNow;
	cop_fmt_t fmtNow;
	logic [2:0] regSel;
	logic [2:0] wordCnt_r;
	logic [79:0] stage_r;
	logic [79:0] stackMem [0:STACK_DEPTH-1];
	cop_fmt_t tagMem [0:STACK_DEPTH-1];
	logic [2:0] top_r;
	logic [2:0] below;
	logic [3:0] depth_r;
	logic [5:0] flags_r, mask_r, excNow;
	logic protMode_r, busyLatch_r, irq_r, errPrev_r;
	logic [79:0] result_r;
	logic [2:0] resLeft_r;
	logic [15:0] rdData_r;
	logic rdValid_r;
	logic [63:0] res64, sa, sb, divisor, quo, rem;
	logic [127:0] prod;
	logic [64:0] sum, diff;

	// Right-justify collected words and sign-extend binary integers
	function automatic logic [79:0] alignOperand(input logic [79:0] raw,
		input cop_fmt_t f);
		logic [79:0] v;
		v = raw >> (16 * (5 - int'(fmtWords(f))));
		case (f)
			FMT_INT16: v = {{64{v[15]}}, v[15:0]};
			FMT_INT32: v = {{48{v[31]}}, v[31:0]};
			FMT_INT64: v = {{16{v[63]}}, v[63:0]};
			default: v = v;
		endcase
		return v;
	endfunction : alignOperand

	function automatic logic isDenormal(input cop_fmt_t f,
		input logic [79:0] v);
		return (f == FMT_REAL80) && (v[78:64] == 15'h0000)
			&& (v[63:0] != 64'h0000000000000000);
	endfunction : isDenormal

	////////////////////////////////////////////////////////////////////
	// Port decode
	assign byteWr = link.ioWr && link.ioByte;
	assign clearHit = byteWr && (link.ioAddr == PORT_CLEAR)
		&& (link.ioWrData[7:0] == 8'h00);
	assign resetHit = byteWr && (link.ioAddr == PORT_RESET);
	assign opcHit = link.ioWr && (link.ioAddr == PORT_OPCODE);
	assign opndHit = link.ioWr && (link.ioAddr == PORT_OPERAND);
	assign opNow = cop_op_t'(opcode_r[OPC_OP_LSB +: 8]);
	assign fmtNow = cop_fmt_t'(opcode_r[OPC_FMT_LSB +: 3]);
	assign regSel = opcode_r[OPC_REG_LSB +: 3];
	assign runEnd = (exState_r == EX_RUN)
		&& (runCnt_r == CNT_W'(EXEC_CYCLES - 1));

	////////////////////////////////////////////////////////////////////
	// Sequencing; the host bus only feeds ports, execution runs on its own
	always_ff @(posedge clk)
	begin
		if (srst || resetHit)
		begin
			exState_r <= EX_IDLE;
			runCnt_r <= '0;
			opcode_r <= 16'h0000;
			wordCnt_r <= 3'h0;
			stage_r <= '0;
		end
		else
		begin
			case (exState_r)
				EX_IDLE:
				begin
					runCnt_r <= '0;
					if (opcHit)
					begin
						opcode_r <= link.ioWrData;
						wordCnt_r <= fmtWords(cop_fmt_t'(link.ioWrData[2:0]));
						if (link.ioWrData[15:8] == OP_LOAD)
							exState_r <= EX_LOAD;
						else
							exState_r <= EX_RUN;
					end
				end
				EX_LOAD:
				begin
					if (opndHit)
					begin
						stage_r <= {link.ioWrData, stage_r[79:16]};
						wordCnt_r <= wordCnt_r - 3'h1;
						if (wordCnt_r == 3'h1)
							exState_r <= EX_RUN;
					end
				end
				EX_RUN:
				begin
					runCnt_r <= runCnt_r + CNT_W'(1);
					if (runEnd)
						exState_r <= EX_IDLE;
				end
				default: exState_r <= EX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Arithmetic on the two top entries; low 64 bits as signed integers
	assign below = top_r - 3'h1;
	assign sa = stackMem[top_r][63:0];
	assign sb = stackMem[below][63:0];
	assign sum = {sb[63], sb} + {sa[63], sa};
	assign diff = {sb[63], sb} - {sa[63], sa};
	assign prod = {{64{sb[63]}}, sb} * {{64{sa[63]}}, sa};
	// Guard zero and the one wrapping case so division stays defined
	assign divisor = ((sa == 64'h0) || ((sa == 64'hFFFFFFFFFFFFFFFF)
		&& (sb == 64'h8000000000000000))) ? 64'h1 : sa;
	assign quo = 64'($signed(sb) / $signed(divisor));
	assign rem = 64'($signed(sb) % $signed(divisor));

	always_comb
	begin
		excNow = '0;
		res64 = '0;
		stackOk = 1'b1;
		case (opNow)
			OP_LOAD, OP_PUSHREG: stackOk = depth_r < 4'(STACK_DEPTH);
			OP_STORE: stackOk = depth_r != 4'h0;
			OP_ADD, OP_SUB, OP_MUL, OP_DIV: stackOk = depth_r >= 4'h2;
			default: stackOk = 1'b1;
		endcase
		excNow[EXC_INVALID] = !stackOk;
		if (stackOk && (opNow inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV}))
		begin
			excNow[EXC_DENORMAL] = isDenormal(tagMem[top_r], stackMem[top_r])
				|| isDenormal(tagMem[below], stackMem[below]);
			case (opNow)
				OP_ADD:
				begin
					res64 = sum[63:0];
					excNow[EXC_OVERFLOW] = sum[64] ^ sum[63];
				end
				OP_SUB:
				begin
					res64 = diff[63:0];
					excNow[EXC_OVERFLOW] = diff[64] ^ diff[63];
				end
				OP_MUL:
				begin
					res64 = prod[63:0];
					excNow[EXC_OVERFLOW] = !((&prod[127:63]) || !(|prod[127:63]));
				end
				default:
				begin
					res64 = quo;
					excNow[EXC_ZERODIV] = sa == 64'h0;
					excNow[EXC_OVERFLOW] = (sa != 64'h0) && (divisor != sa);
					excNow[EXC_UNDERFLOW] = (sa != 64'h0) && (quo == 64'h0)
						&& (sb != 64'h0);
					excNow[EXC_PRECISION] = (sa != 64'h0) && (rem != 64'h0);
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Eight-entry register file; physical index for fixed use
	always_ff @(posedge clk)
	begin
		if (srst || resetHit)
		begin
			top_r <= 3'h0;
			depth_r <= 4'h0;
		end
		else if (runEnd && stackOk)
		begin
			case (opNow)
				OP_LOAD, OP_PUSHREG:
				begin
					top_r <= top_r + 3'h1;
					depth_r <= depth_r + 4'h1;
					stackMem[top_r + 3'h1] <= (opNow == OP_LOAD) ?
						alignOperand(stage_r, fmtNow) : stackMem[regSel];
					tagMem[top_r + 3'h1] <= (opNow == OP_LOAD) ?
						fmtNow : tagMem[regSel];
				end
				OP_STORE:
				begin
					top_r <= below;
					depth_r <= depth_r - 4'h1;
				end
				OP_ADD, OP_SUB, OP_MUL, OP_DIV:
				begin
					stackMem[below] <= {{16{res64[63]}}, res64};
					tagMem[below] <= FMT_INT64;
					top_r <= below;
					depth_r <= depth_r - 4'h1;
				end
				default: top_r <= top_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Exception flags, masks and operating mode
	always_ff @(posedge clk)
	begin
		if (srst || resetHit)
		begin
			flags_r <= '0;
			mask_r <= MASK_RESET;
			protMode_r <= 1'b0;
		end
		else if (runEnd)
		begin
			flags_r <= (opNow == OP_CLREX) ? '0 : (flags_r | excNow);
			if (opNow == OP_SETMASK)
				mask_r <= opcode_r[5:0];
			if (opNow == OP_SET_PROTECTED_MODE_ESCAPE)
				protMode_r <= 1'b1;
		end
	end

	assign errNow = |(flags_r & ~mask_r);
	assign errRise = errNow && !errPrev_r;

	// Edge-set latches so a clear sticks while error stays high
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			busyLatch_r <= 1'b0;
			irq_r <= 1'b0;
			errPrev_r <= 1'b0;
		end
		else
		begin
			errPrev_r <= errNow;
			if (errRise)
			begin
				busyLatch_r <= 1'b1;
				irq_r <= 1'b1;
			end
			else if (clearHit)
			begin
				busyLatch_r <= 1'b0;
				irq_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read answers and result buffer
	always_ff @(posedge clk)
	begin
		if (srst || resetHit)
		begin
			result_r <= '0;
			resLeft_r <= 3'h0;
		end
		else if (runEnd && stackOk && (opNow == OP_STORE))
		begin
			result_r <= stackMem[top_r];
			resLeft_r <= fmtWords(fmtNow);
		end
		else if (link.ioRd && (link.ioAddr == PORT_RESULT)
			&& (resLeft_r != 3'h0))
		begin
			result_r <= {16'h0000, result_r[79:16]};
			resLeft_r <= resLeft_r - 3'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rdValid_r <= 1'b0;
			rdData_r <= 16'h0000;
		end
		else
		begin
			rdValid_r <= link.ioRd;
			case (link.ioAddr)
				PORT_OPCODE: rdData_r <= opcode_r;
				PORT_OPERAND: rdData_r <= {4'h0, depth_r, link.busy,
					protMode_r, flags_r};
				PORT_RESULT: rdData_r <= (resLeft_r != 3'h0) ?
					result_r[15:0] : 16'h0000;
				default: rdData_r <= 16'h0000;
			endcase
		end
	end

	assign link.busy = (exState_r == EX_RUN) || busyLatch_r;
	assign link.error = errNow;
	assign link.irq13 = irq_r;
	assign link.ioRdData = rdData_r;
	assign link.ioRdValid = rdValid_r;
	assign protMode = protMode_r;
	assign excFlags = flags_r;
	assign stackDepth = depth_r;
endmodule : math_cop_device

// file: common/math_cop_pkg.sv
// Constants and types shared by both ends of the coprocessor port link
////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////
package math_cop_pkg;
	localparam int CLK_MHZ = 100;
	localparam logic [15:0] PORT_OPCODE = 16'h00F8;
	localparam logic [15:0] PORT_OPERAND = 16'h00FA;
	localparam logic [15:0] PORT_RESULT = 16'h00FC;
	localparam logic [15:0] PORT_CLEAR = 16'h00F0;
	localparam logic [15:0] PORT_RESET = 16'h00F1;
	localparam int STACK_DEPTH = 8;
	localparam int DATA_W = 80;
	localparam int EXC_COUNT = 6;
	localparam int EXC_INVALID = 0;
	localparam int EXC_DENORMAL = 1;
	localparam int EXC_ZERODIV = 2;
	localparam int EXC_OVERFLOW = 3;
	localparam int EXC_UNDERFLOW = 4;
	localparam int EXC_PRECISION = 5;
	localparam logic [5:0] MASK_RESET = 6'h3F;
	// Opcode word: [15:8] operation, [6:4] register, [2:0] format
	localparam int OPC_OP_LSB = 8;
	localparam int OPC_REG_LSB = 4;
	localparam int OPC_FMT_LSB = 0;
	// Status word on operand-port read
	localparam int STS_MODE_BIT = 6;
	localparam int STS_BUSY_BIT = 7;
	localparam int STS_DEPTH_LSB = 8;
	localparam int EXEC_TIME_NS = 80;
	localparam int EXEC_CYCLES = (EXEC_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 4;

	typedef enum logic [7:0]
	{
		OP_LOAD = 8'h01,
		OP_STORE = 8'h02,
		OP_ADD = 8'h03,
		OP_SUB = 8'h04,
		OP_MUL = 8'h05,
		OP_DIV = 8'h06,
		OP_PUSHREG = 8'h07,
		OP_SETMASK = 8'h08,
		OP_CLREX = 8'h09,
		OP_SET_PROTECTED_MODE_ESCAPE = 8'h0A
	} cop_op_t;

	typedef enum logic [2:0]
	{
		FMT_INT16 = 3'h0,
		FMT_INT32 = 3'h1,
		FMT_INT64 = 3'h2,
		FMT_BCD80 = 3'h3,
		FMT_REAL32 = 3'h4,
		FMT_REAL64 = 3'h5,
		FMT_REAL80 = 3'h6
	} cop_fmt_t;

	typedef enum logic [1:0]
	{
		EX_IDLE = 2'b00,
		EX_LOAD = 2'b01,
		EX_RUN = 2'b11
	} exec_state_t;

	typedef enum logic [1:0]
	{
		HS_IDLE = 2'b00,
		HS_ACCESS = 2'b01,
		HS_READ = 2'b11,
		HS_WAIT = 2'b10
	} host_state_t;

	typedef enum logic [1:0]
	{
		CMD_WRITE = 2'h0,
		CMD_READ = 2'h1,
		CMD_WAIT = 2'h2
	} host_cmd_t;

	// 16-bit words carried per value of a format
	function automatic logic [2:0] fmtWords(input cop_fmt_t f);
		case (f)
			FMT_INT16: fmtWords = 3'h1;
			FMT_INT32: fmtWords = 3'h2;
			FMT_REAL32: fmtWords = 3'h2;
			FMT_INT64: fmtWords = 3'h4;
			FMT_REAL64: fmtWords = 3'h4;
			default: fmtWords = 3'h5;
		endcase
	endfunction : fmtWords
endpackage : math_cop_pkg

// file: common/cop_link_if.sv
// I/O-cycle link between the host end and the coprocessor end
`timescale 1ns/1ps
interface cop_link_if;
	logic [15:0] ioAddr;
	logic [15:0] ioWrData;
	logic ioWr;
	logic ioRd;
	logic ioByte;
	logic [15:0] ioRdData;
	logic ioRdValid;
	logic busy;
	logic error;
	logic irq13;

	modport device
	(
		input ioAddr, ioWrData, ioWr, ioRd, ioByte,
		output ioRdData, ioRdValid, busy, error, irq13
	);
	modport host
	(
		output ioAddr, ioWrData, ioWr, ioRd, ioByte,
		input ioRdData, ioRdValid, busy, error, irq13
	);
endinterface : cop_link_if

// file: logic/math_cop_host.sv
// Host end: turns user commands into I/O cycles and wait stalls
`timescale 1ns/1ps
module math_cop_host
	import math_cop_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	cop_link_if.host link,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire host_cmd_t cmdKind,
	input wire logic [15:0] cmdAddr,
	input wire logic [15:0] cmdData,
	input wire logic cmdByte,
	output logic respValid,
	output logic [15:0] respData,
	output logic irqReq13,
	output logic copBusy
);
	////////////////////////////////////////////////////////////////////
	host_state_t state_r;
	host_cmd_t kind_r;
	logic [15:0] addr_r, data_r, respData_r;
	logic byte_r, respValid_r, irq_r, busy_r;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_r <= HS_IDLE;
			kind_r <= CMD_WRITE;
			addr_r <= 16'h0000;
			data_r <= 16'h0000;
			byte_r <= 1'b0;
			respValid_r <= 1'b0;
			respData_r <= 16'h0000;
		end
		else
		begin
			respValid_r <= 1'b0;
			case (state_r)
				HS_IDLE:
				begin
					if (cmdValid)
					begin
						kind_r <= cmdKind;
						addr_r <= cmdAddr;
						data_r <= cmdData;
						byte_r <= cmdByte;
						state_r <= (cmdKind == CMD_WAIT) ? HS_WAIT : HS_ACCESS;
					end
				end
				HS_ACCESS:
				begin
					if (kind_r == CMD_READ)
						state_r <= HS_READ;
					else
					begin
						respValid_r <= 1'b1;
						state_r <= HS_IDLE;
					end
				end
				HS_READ:
				begin
					if (link.ioRdValid)
					begin
						respData_r <= link.ioRdData;
						respValid_r <= 1'b1;
						state_r <= HS_IDLE;
					end
				end
				HS_WAIT:
				begin
					// Stalls until the coprocessor frees the bus
					if (!link.busy)
					begin
						respValid_r <= 1'b1;
						state_r <= HS_IDLE;
					end
				end
				default: state_r <= HS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			irq_r <= 1'b0;
			busy_r <= 1'b0;
		end
		else
		begin
			irq_r <= link.irq13;
			busy_r <= link.busy;
		end
	end

	assign cmdReady = state_r == HS_IDLE;
	assign link.ioAddr = addr_r;
	assign link.ioWrData = data_r;
	assign link.ioByte = byte_r;
	assign link.ioWr = (state_r == HS_ACCESS) && (kind_r == CMD_WRITE);
	assign link.ioRd = (state_r == HS_ACCESS) && (kind_r == CMD_READ);
	assign respValid = respValid_r;
	assign respData = respData_r;
	assign irqReq13 = irq_r;
	assign copBusy = busy_r;
endmodule : math_cop_host

// file: tb/cop_link_props.sv
// Concurrent checks on the signals of the coprocessor link
`timescale 1ns/1ps
module cop_link_props
	import math_cop_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [15:0] ioAddr,
	input wire logic [15:0] ioWrData,
	input wire logic ioWr,
	input wire logic ioRd,
	input wire logic ioByte,
	input wire logic [15:0] ioRdData,
	input wire logic ioRdValid,
	input wire logic busy,
	input wire logic error,
	input wire logic irq13
);
	logic clrWr;
	logic addOp;
	assign clrWr = ioWr && ioByte && (ioAddr == PORT_CLEAR)
		&& (ioWrData[7:0] == 8'h00);
	assign addOp = ioWr && (ioAddr == PORT_OPCODE)
		&& (ioWrData[15:8] == OP_ADD);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////////////
	rd_answer_a: assert property (ioRd |=> ioRdValid)
		else $error("read not answered");
	rd_spurious_a: assert property (!ioRd |=> !ioRdValid)
		else $error("answer without read");
	clr_read_a: assert property (ioRd && ioAddr == PORT_CLEAR
		|=> ioRdData == 16'h0000)
		else $error("clear port read not zero");
	err_raise_a: assert property ($rose(error) |=> irq13 && busy)
		else $error("error did not raise request and busy");
	irq_cause_a: assert property ($rose(irq13) |-> $past(error))
		else $error("request raised without error");
	irq_hold_a: assert property (irq13 && !clrWr |=> irq13)
		else $error("request dropped without clear");
	clr_irq_a: assert property (clrWr && !$rose(error) |=> !irq13)
		else $error("clear write left request set");
	byte_only_a: assert property (ioWr && !ioByte && irq13 |=> irq13)
		else $error("word write cleared request");
	busy_run_a: assert property (addOp && !busy |=> busy [*8])
		else $error("busy not held for the run");
	////////////////////////////////////////////////////////////////////////
	irq_seen_c: cover property ($rose(irq13));
	clr_seen_c: cover property (clrWr && irq13);
	run_seen_c: cover property (busy [*8]);
endmodule : cop_link_props

// file: tb/testbench.sv
// Testbench: host user side drives both ends joined by the link
`timescale 1ns/1ps
module testbench;
	import math_cop_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic cmdValid = 1'b0;
	logic cmdReady;
	host_cmd_t cmdKind = CMD_WRITE;
	logic [15:0] cmdAddr = 16'h0000;
	logic [15:0] cmdData = 16'h0000;
	logic cmdByte = 1'b0;
	logic respValid;
	logic [15:0] respData;
	logic irqReq13;
	logic copBusy;
	logic protMode;
	logic [EXC_COUNT-1:0] excFlags;
	logic [3:0] stackDepth;
	logic [15:0] rdData;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	// One entry per exception class: operands, operation, expected flags
	logic [79:0] aVal [6] = '{80'h0, 80'h1, 80'h1, 80'h4000_0000_0000_0000,
		80'h1, 80'h7};
	logic [15:0] bVal [6] = '{16'h0000, 16'h0001, 16'h0000, 16'h0002,
		16'h0005, 16'h0002};
	cop_fmt_t aFmt [6] = '{FMT_INT16, FMT_REAL80, FMT_INT16, FMT_INT64,
		FMT_INT16, FMT_INT16};
	cop_op_t opc [6] = '{OP_ADD, OP_ADD, OP_DIV, OP_MUL, OP_DIV, OP_DIV};
	logic [5:0] expF [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h30, 6'h20};
	cop_link_if link();
	math_cop_device math_cop_device_inst (.clk(clk), .srst(srst),
		.link(link), .protMode(protMode), .excFlags(excFlags),
		.stackDepth(stackDepth));
	math_cop_host math_cop_host_inst (.clk(clk), .srst(srst), .link(link),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdKind(cmdKind),
		.cmdAddr(cmdAddr), .cmdData(cmdData), .cmdByte(cmdByte),
		.respValid(respValid), .respData(respData), .irqReq13(irqReq13),
		.copBusy(copBusy));
	cop_link_props cop_link_props_inst (.clk(clk), .srst(srst),
		.ioAddr(link.ioAddr), .ioWrData(link.ioWrData), .ioWr(link.ioWr),
		.ioRd(link.ioRd), .ioByte(link.ioByte), .ioRdData(link.ioRdData),
		.ioRdValid(link.ioRdValid), .busy(link.busy), .error(link.error),
		.irq13(link.irq13));
	always #5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	// Generous ceiling: the sequence needs well under two thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			test_done();
		end
	end
	task automatic chk(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		n_tests++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	endtask : chk
	task automatic cmd(input host_cmd_t k, input logic [15:0] a,
		input logic [15:0] d, input logic b);
		int i;
		@(negedge clk);
		cmdValid = 1'b1;
		cmdKind = k;
		cmdAddr = a;
		cmdData = d;
		cmdByte = b;
		for (i = 0; i < 20 && cmdReady !== 1'b1; i++)
			@(negedge clk);
		@(negedge clk);
		cmdValid = 1'b0;
		chk("cmdReady", 16'h0000, 16'(cmdReady));
		for (i = 0; i < 60 && respValid !== 1'b1; i++)
			@(negedge clk);
		rdData = respData;
		chk("respValid", 16'h0001, 16'(respValid));
	endtask : cmd
	task automatic wr(input logic [15:0] a, input logic [15:0] d,
		input logic b);
		cmd(CMD_WRITE, a, d, b);
	endtask : wr
	task automatic rd(input logic [15:0] a);
		cmd(CMD_READ, a, 16'h0000, 1'b0);
	endtask : rd
	task automatic wt;
		cmd(CMD_WAIT, 16'h0000, 16'h0000, 1'b0);
	endtask : wt
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle
	task automatic load(input cop_fmt_t f, input logic [79:0] v);
		int i;
		int nw;
		case (f)
			FMT_INT16: nw = 1;
			FMT_INT32, FMT_REAL32: nw = 2;
			FMT_INT64, FMT_REAL64: nw = 4;
			default: nw = 5;
		endcase
		wr(PORT_OPCODE, {OP_LOAD, 5'h00, f}, 1'b0);
		for (i = 0; i < nw; i++)
			wr(PORT_OPERAND, v[16*i +: 16], 1'b0);
		wt();
	endtask : load
	task automatic waitIrq;
		int i;
		for (i = 0; i < 40 && irqReq13 !== 1'b1; i++)
			@(negedge clk);
		chk("irqReq13", 16'h0001, 16'(irqReq13));
	endtask : waitIrq
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		idle(16);
		srst = 1'b0;
		chk("irqReq13", 16'h0000, 16'(irqReq13));
		chk("protMode", 16'h0000, 16'(protMode));
		rd(PORT_OPERAND);
		chk("status", 16'h0000, rdData);
		load(FMT_INT16, 80'h5);
		load(FMT_INT16, 80'h3);
		rd(PORT_OPERAND);
		chk("status", 16'h0200, rdData);
		wr(PORT_OPCODE, {OP_ADD, 8'h00}, 1'b0);
		rd(PORT_OPERAND);
		chk("busyBit", 16'h0001, 16'(rdData[STS_BUSY_BIT]));
		wt();
		chk("stackDepth", 16'h0001, 16'(stackDepth));
		wr(PORT_OPCODE, {OP_STORE, 5'h00, FMT_INT16}, 1'b0);
		wt();
		rd(PORT_RESULT);
		chk("result", 16'h0008, rdData);
		rd(PORT_RESULT);
		chk("resultEnd", 16'h0000, rdData);
		// Two- and four-word formats, subtract, wide store
		load(FMT_INT32, 80'hFFFFFFFE);
		load(FMT_REAL64, 80'h5);
		wr(PORT_OPCODE, {OP_SUB, 8'h00}, 1'b0);
		wt();
		wr(PORT_OPCODE, {OP_STORE, 5'h00, FMT_INT64}, 1'b0);
		wt();
		for (int j = 0; j < 5; j++)
		begin
			rd(PORT_RESULT);
			chk("result64", (j == 0) ? 16'hFFF9 : (j < 4) ? 16'hFFFF :
				16'h0000, rdData);
		end
		// Fixed-register copy: physical entry 2 still holds the 5
		wr(PORT_OPCODE, {OP_PUSHREG, 8'h20}, 1'b0);
		wt();
		wr(PORT_OPCODE, {OP_STORE, 5'h00, FMT_REAL32}, 1'b0);
		wt();
		rd(PORT_RESULT);
		chk("pushReg", 16'h0005, rdData);
		rd(PORT_RESULT);
		chk("pushRegHi", 16'h0000, rdData);
		// Store from an empty stack flags invalid; masked, so no request
		wr(PORT_OPCODE, {OP_STORE, 5'h00, FMT_INT16}, 1'b0);
		wt();
		chk("excFlags", 16'h0001, 16'(excFlags));
		chk("irqReq13", 16'h0000, 16'(irqReq13));
		wr(PORT_OPCODE, {OP_CLREX, 8'h00}, 1'b0);
		wt();
		chk("excFlags", 16'h0000, 16'(excFlags));
		wr(PORT_OPCODE, {OP_SET_PROTECTED_MODE_ESCAPE, 8'h00}, 1'b0);
		wt();
		chk("protMode", 16'h0001, 16'(protMode));
		wr(PORT_RESET, 16'h0000, 1'b0);
		rd(PORT_RESET);
		chk("protMode", 16'h0001, 16'(protMode));
		wr(PORT_RESET, 16'h0000, 1'b1);
		idle(2);
		chk("protMode", 16'h0000, 16'(protMode));
		wr(PORT_OPCODE, {OP_SET_PROTECTED_MODE_ESCAPE, 8'h00}, 1'b0);
		wt();
		wr(PORT_RESET, 16'h00A5, 1'b1);
		idle(2);
		chk("protMode", 16'h0000, 16'(protMode));
		for (int k = 0; k < 6; k++)
		begin
			wr(PORT_RESET, 16'h0000, 1'b1);
			wr(PORT_OPCODE, {OP_SETMASK, 8'h00}, 1'b0);
			wt();
			if (k > 0)
			begin
				load(aFmt[k], aVal[k]);
				load(FMT_INT16, {64'h0, bVal[k]});
			end
			wr(PORT_OPCODE, {opc[k], 8'h00}, 1'b0);
			waitIrq();
			chk("excFlags", {10'h000, expF[k]}, 16'(excFlags));
			idle(12);
			chk("copBusy", 16'h0001, 16'(copBusy));
			wr(PORT_CLEAR, 16'h0000, 1'b0);
			wr(PORT_CLEAR, 16'h0001, 1'b1);
			rd(PORT_CLEAR);
			idle(2);
			chk("irqReq13", 16'h0001, 16'(irqReq13));
			wr(PORT_CLEAR, 16'h0000, 1'b1);
			idle(3);
			chk("irqReq13", 16'h0000, 16'(irqReq13));
			chk("copBusy", 16'h0000, 16'(copBusy));
		end
		// After a coprocessor reset every class is masked again
		wr(PORT_RESET, 16'h0000, 1'b1);
		load(FMT_INT16, 80'h1);
		load(FMT_INT16, 80'h0);
		wr(PORT_OPCODE, {OP_DIV, 8'h00}, 1'b0);
		wt();
		chk("excFlags", 16'h0004, 16'(excFlags));
		chk("irqReq13", 16'h0000, 16'(irqReq13));
		wr(PORT_OPCODE, {OP_SETMASK, 8'h00}, 1'b0);
		wt();
		wr(PORT_OPCODE, {OP_ADD, 8'h00}, 1'b0);
		waitIrq();
		srst = 1'b1;
		idle(2);
		srst = 1'b0;
		idle(3);
		chk("irqReq13", 16'h0000, 16'(irqReq13));
		chk("copBusy", 16'h0000, 16'(copBusy));
		test_done();
	end
endmodule : testbench
